// file: design/eiopc_top.sv
`timescale 1ns/100ps
module eiopc_top import eiopc_pkg::*; #(
  parameter int PORTS     = 17,
  parameter int EXPANDERS = 16
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [PORTS*8-1:0]   pin_in,
  output logic      [PORTS*8-1:0]   pin_out,
  output logic      [PORTS*8-1:0]   pin_oe,
  input  wire logic [EXPANDERS-1:0] expander_present,
  output logic                      port_change_handler,
  output logic                      pin_change_handler
);
  localparam int PINS = PORTS * 8;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  // Eight levels of one port, zero beyond the last port
  function automatic logic [7:0] port_bits(input logic [PINS-1:0] v, input logic [7:0] p);
    logic [PINS-1:0] sh;
    sh = v >> {p, 3'b000};
    port_bits = (int'(p) < PORTS) ? sh[7:0] : 8'h00;
  endfunction : port_bits

  function automatic logic pin_bit(input logic [PINS-1:0] v, input logic [7:0] p);
    pin_bit = (int'(p) < PINS) ? v[p] : 1'b0;
  endfunction : pin_bit

  // ***************************************************************
  // Input synchronisers and change detection
  // ***************************************************************
  logic [PINS-1:0]      pin_s1, pin_s2, pin_s3, pin_level;
  logic [EXPANDERS-1:0] pres_s1, pres_s2, pres_s3, pres_level;
  logic [PINS-1:0]      change;
  logic                 change_seen;
  logic [7:0]           ctrl;
  logic [3:0]           primed;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_s1  <= '0;
      pin_s2  <= '0;
      pin_s3  <= '0;
      pres_s1 <= '0;
      pres_s2 <= '0;
      pres_s3 <= '0;
      primed  <= 4'h0;
    end else begin
      pin_s1  <= pin_in;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      pres_s1 <= expander_present;
      pres_s2 <= pres_s1;
      pres_s3 <= pres_s2;
      primed  <= {primed[2:0], 1'b1};
    end
  end

  // Only input pins report changes; held off until the stages carry real pad samples,
  // otherwise pads idling high would look like a change straight after reset
  assign change = ~(pin_s2 ^ pin_s3) & (pin_s2 ^ pin_level) & ~pin_oe
                  & {PINS{primed[3]}};

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_level           <= '0;
      pres_level          <= '0;
      port_change_handler <= 1'b0;
      pin_change_handler  <= 1'b0;
    end else begin
      pin_level  <= (pin_s2 & pin_s3) | (pin_level & (pin_s2 ^ pin_s3));
      pres_level <= (pres_s2 & pres_s3) | (pres_level & (pres_s2 ^ pres_s3));
      port_change_handler <= ctrl[0] & (|change);
      pin_change_handler  <= ctrl[1] & (|change);
    end
  end

  // ***************************************************************
  // AXI4-Lite slave
  // ***************************************************************
  logic       wr_go, rd_go, cmd_wr, data_wr, reply_rd, status_wr;
  logic [7:0] wval;

  assign wr_go     = s_axi_awvalid & s_axi_awready;
  assign rd_go     = s_axi_arvalid & s_axi_arready;
  assign wval      = s_axi_wdata[7:0];
  assign cmd_wr    = wr_go & (s_axi_awaddr == CMD_OFFSET);
  assign data_wr   = wr_go & (s_axi_awaddr == DATA_OFFSET);
  assign status_wr = wr_go & (s_axi_awaddr == STATUS_OFFSET);
  assign reply_rd  = rd_go & (s_axi_araddr == REPLY_OFFSET);

  // Address and data taken together once both are offered
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr inside {CMD_OFFSET, DATA_OFFSET, STATUS_OFFSET,
                         CTRL_OFFSET}) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Command decode and pin state
  // ***************************************************************
  logic [2:0] cur_op;
  logic [7:0] cur_idx;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cur_op  <= 3'h0;
      cur_idx <= 8'h00;
    end else if (cmd_wr) begin
      cur_op  <= s_axi_wdata[CMD_OP_LSB +: 3];
      cur_idx <= s_axi_wdata[CMD_START_LSB +: 8];
    end else if (data_wr) begin
      cur_idx <= cur_idx + 8'h01;
    end
  end

  // Out-of-range ports or pins are ignored rather than wrapped
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_oe  <= {PINS{PIN_OE_RESET}};
      pin_out <= {PINS{PIN_OUT_RESET}};
    end else if (data_wr) begin
      case (cur_op)
        OP_PORT_DIR: begin
          if (int'(cur_idx) < PORTS) pin_oe[cur_idx*8 +: 8] <= ~wval;
        end
        OP_PORT_WR: begin
          if (int'(cur_idx) < PORTS) pin_out[cur_idx*8 +: 8] <= wval;
        end
        OP_PIN_DIR: begin
          if (int'(cur_idx) < PINS) pin_oe[cur_idx] <= ~wval[0];
        end
        OP_PIN_WR: begin
          if (int'(cur_idx) < PINS) begin
            if (wval[1:0] == PIN_SET_TOGGLE) pin_out[cur_idx] <= ~pin_out[cur_idx];
            else if (wval[1:0] < PIN_SET_TOGGLE) pin_out[cur_idx] <= wval[0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Handler enables and sticky change flag; a new change beats a clear
  logic change_flag;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl        <= CTRL_RESET;
      change_flag <= 1'b0;
    end else begin
      if (wr_go && s_axi_awaddr == CTRL_OFFSET) ctrl <= wval;
      if (|change) change_flag <= 1'b1;
      else if (status_wr && s_axi_wdata[STATUS_CHANGE_BIT]) change_flag <= 1'b0;
    end
  end
  assign change_seen = |change;

  // ***************************************************************
  // Reply generator, bytes built on the fly from live pin levels
  // ***************************************************************
  eiopc_state_type state;
  logic [2:0] rep_op;
  logic [7:0] rep_start, rep_cnt, rep_byte, cmd_cnt;
  logic [8:0] rep_pos, rep_len;
  logic       rd_cmd;

  assign rd_cmd  = cmd_wr & (s_axi_wdata[CMD_OP_LSB +: 3] inside {OP_PORT_RD, OP_PRESENCE,
                   OP_PIN_RD});
  assign cmd_cnt = s_axi_wdata[CMD_COUNT_LSB +: 8];

  // A read command arriving while a reply is pending is dropped
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state     <= EIOPC_IDLE;
      rep_op    <= 3'h0;
      rep_start <= 8'h00;
      rep_cnt   <= 8'h00;
      rep_pos   <= 9'h000;
      rep_len   <= 9'h000;
    end else begin
      case (state)
        EIOPC_IDLE: begin
          if (rd_cmd) begin
            state     <= EIOPC_BUSY;
            rep_op    <= s_axi_wdata[CMD_OP_LSB +: 3];
            rep_start <= s_axi_wdata[CMD_START_LSB +: 8];
            rep_pos   <= 9'h000;
            if (s_axi_wdata[CMD_OP_LSB +: 3] == OP_PRESENCE) begin
              rep_cnt <= 8'h00;
              rep_len <= REPLY_HEAD_LEN;
            end else begin
              if (cmd_cnt != 8'h00) rep_cnt <= cmd_cnt;
              else if (s_axi_wdata[CMD_OP_LSB +: 3] == OP_PIN_RD)
                rep_cnt <= PIN_RD_DEFAULT_COUNT;
              else rep_cnt <= PORT_RD_DEFAULT_COUNT;
              rep_len <= REPLY_HEAD_LEN + {1'b0, (cmd_cnt != 8'h00) ? cmd_cnt :
                         (s_axi_wdata[CMD_OP_LSB +: 3] == OP_PIN_RD) ?
                         PIN_RD_DEFAULT_COUNT : PORT_RD_DEFAULT_COUNT};
            end
          end
        end
        EIOPC_BUSY: begin
          if (reply_rd) begin
            rep_pos <= rep_pos + 9'h001;
            if (rep_pos + 9'h001 == rep_len) state <= EIOPC_IDLE;
          end
        end
        default: state <= EIOPC_IDLE;
      endcase
    end
  end

  // Byte at the current reply position
  always_comb begin
    logic [7:0] k;
    k = rep_pos[7:0] - 8'h06;
    case (rep_pos)
      9'h000: rep_byte = BYTE_ESC;
      9'h001: rep_byte = BYTE_GROUP;
      9'h002: rep_byte = (rep_op == OP_PIN_RD) ? BYTE_PIN : BYTE_PORT;
      9'h003: rep_byte = (rep_op == OP_PRESENCE) ? BYTE_INFO : BYTE_READ;
      9'h004: rep_byte = (rep_op == OP_PRESENCE) ? 8'(pres_level) : rep_start;
      9'h005: rep_byte = (rep_op == OP_PRESENCE) ? 8'(pres_level >> 8) : rep_cnt;
      default: begin
        if (rep_op == OP_PIN_RD) rep_byte = {7'h00, pin_bit(pin_level, rep_start + k)};
        else rep_byte = port_bits(pin_level, rep_start + k);
      end
    endcase
  end

  // Read data mux; reading REPLY pops one byte
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          CMD_OFFSET:    s_axi_rdata <= {8'h00, rep_cnt, cur_idx, 5'h00, cur_op};
          REPLY_OFFSET:  s_axi_rdata <= {23'h0, state == EIOPC_BUSY,
                                         (state == EIOPC_BUSY) ? rep_byte : 8'h00};
          STATUS_OFFSET: s_axi_rdata <= {14'h0, state == EIOPC_BUSY, change_flag,
                                         16'(pres_level)};
          CTRL_OFFSET:   s_axi_rdata <= {24'h0, ctrl};
          DATA_OFFSET:   s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_DECERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_read_cmd_idle;
    rd_cmd && state == EIOPC_IDLE;
  endsequence
  sequence s_reply_open;
    state == EIOPC_BUSY && rep_pos == 9'h000 && rep_byte == BYTE_ESC;
  endsequence

  a_port_dir_set: assert property (data_wr && cur_op == OP_PORT_DIR && int'(cur_idx) < PORTS
    |=> pin_oe[$past(cur_idx)*8 +: 8] == ~$past(wval))
    else $error("port direction not applied");
  a_port_out_set: assert property (data_wr && cur_op == OP_PORT_WR && int'(cur_idx) < PORTS
    |=> pin_out[$past(cur_idx)*8 +: 8] == $past(wval))
    else $error("port output not applied");
  a_index_advance: assert property (data_wr |=> cur_idx == $past(cur_idx) + 8'h01)
    else $error("index did not advance");
  a_pin_dir_set: assert property (data_wr && cur_op == OP_PIN_DIR && int'(cur_idx) < PINS
    |=> pin_oe[$past(cur_idx)] == !$past(wval[0]))
    else $error("pin direction not applied");
  a_pin_toggle: assert property (data_wr && cur_op == OP_PIN_WR && wval[1:0] == PIN_SET_TOGGLE
    && int'(cur_idx) < PINS |=> pin_out[$past(cur_idx)] != $past(pin_out[cur_idx]))
    else $error("pin did not toggle");
  a_reply_start: assert property (s_read_cmd_idle |=> s_reply_open)
    else $error("reply does not open with escape");
  a_presence_len: assert property (s_read_cmd_idle and (s_axi_wdata[2:0] == OP_PRESENCE)
    |=> rep_len == 9'h006 ##0 (state == EIOPC_BUSY) [*1])
    else $error("presence reply length wrong");
  a_presence_mask: assert property (state == EIOPC_BUSY && rep_op == OP_PRESENCE
    && rep_pos == 9'h004 |-> rep_byte == pres_level[7:0])
    else $error("presence mask byte wrong");
  a_pin_rd_default: assert property (s_read_cmd_idle and (s_axi_wdata[2:0] == OP_PIN_RD
    && cmd_cnt == 8'h00) |=> rep_cnt == 8'h08 && rep_len == 9'h00E)
    else $error("pin read default count wrong");
  a_change_launch: assert property (change_seen && ctrl[0] |=> port_change_handler)
    else $error("port handler not launched");
  a_reset_inputs: assert property ($fell(reset) |-> pin_oe == '0)
    else $error("pins not inputs after reset");
  a_pin_count: assert property (data_wr && cur_op == OP_PIN_DIR && int'(cur_idx) >= PINS
    |=> $stable(pin_oe))
    else $error("pin beyond last line changed direction");
endmodule : eiopc_top

// file: design/eiopc_pkg.sv
// How it works
// - Eight internal pins plus up to sixteen external expander ports of eight pins give 136 lines.
// - A port direction command sets each pin of the chosen port from its bit, 0 output, 1 input.
// - A port write command drives each pin of the chosen port from its bit, 0 low, 1 high.
// - Every further value of a port or pin command goes to the next higher port or pin.
// - A port read queues ESC, 0x48 0x50 0x52, start port, count and one state byte per port.
// - A presence query queues ESC, 0x48 0x50 0x49 and a 16-bit mask, one bit per expander.
// - The presence mask holds only the external expanders, never the internal port.
// - A pin direction command makes the pin an output for 0 and an input for 1.
// - A pin write drives low for 0, high for 1 and inverts the present level for 2.
// - A pin read queues ESC, 0x48 0x42 0x52, start pin, count and one byte per pin, default 0 and 8.
// - Changes on input pins are detected and can launch the port or pin change handler.
package eiopc_pkg;
  // ***************************************************************
  // Register map and fields
  // ***************************************************************
  localparam logic [7:0] CMD_OFFSET    = 8'h00;
  localparam logic [7:0] DATA_OFFSET   = 8'h04;
  localparam logic [7:0] REPLY_OFFSET  = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] CTRL_OFFSET   = 8'h10;
  localparam int CMD_OP_LSB     = 0;
  localparam int CMD_START_LSB  = 8;
  localparam int CMD_COUNT_LSB  = 16;
  localparam int REPLY_VALID_BIT = 8;
  localparam int STATUS_CHANGE_BIT = 16;
  localparam int STATUS_BUSY_BIT   = 17;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  // ***************************************************************
  // Commands and reply framing
  // ***************************************************************
  localparam logic [2:0] OP_PORT_DIR  = 3'h1;
  localparam logic [2:0] OP_PORT_WR   = 3'h2;
  localparam logic [2:0] OP_PORT_RD   = 3'h3;
  localparam logic [2:0] OP_PRESENCE  = 3'h4;
  localparam logic [2:0] OP_PIN_DIR   = 3'h5;
  localparam logic [2:0] OP_PIN_WR    = 3'h6;
  localparam logic [2:0] OP_PIN_RD    = 3'h7;
  localparam logic [7:0] BYTE_ESC     = 8'h1B;
  localparam logic [7:0] BYTE_GROUP   = 8'h48;
  localparam logic [7:0] BYTE_PORT    = 8'h50;
  localparam logic [7:0] BYTE_PIN     = 8'h42;
  localparam logic [7:0] BYTE_READ    = 8'h52;
  localparam logic [7:0] BYTE_INFO    = 8'h49;
  localparam logic [7:0] PORT_RD_DEFAULT_COUNT = 8'h01;
  localparam logic [7:0] PIN_RD_DEFAULT_COUNT  = 8'h08;
  localparam logic [8:0] REPLY_HEAD_LEN = 9'h006;
  localparam logic [1:0] PIN_SET_TOGGLE = 2'h2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic PIN_OE_RESET  = 1'b0;
  localparam logic PIN_OUT_RESET = 1'b0;
  // Reply generator states
  typedef enum logic [1:0] {
    EIOPC_IDLE = 2'b01,
    EIOPC_BUSY = 2'b10
  } eiopc_state_type;
endpackage : eiopc_pkg

// file: dv/eiopc_pin_model.sv
`timescale 1ns/100ps
// ***************************************************************
// Pads and expander sockets seen from outside the block
// ***************************************************************
module eiopc_pin_model import eiopc_pkg::*; #(
  parameter int PORTS     = 17,
  parameter int EXPANDERS = 16
) (
  input  wire logic [PORTS*8-1:0]   pin_out,
  input  wire logic [PORTS*8-1:0]   pin_oe,
  input  wire logic [PORTS*8-1:0]   ext_level,
  input  wire logic [EXPANDERS-1:0] present_cfg,
  output logic      [PORTS*8-1:0]   pin_in,
  output logic      [EXPANDERS-1:0] expander_present
);
  // A driven pad follows the block, a released one the outside world
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
  // Sockets report only plugged expanders; the internal port has none
  assign expander_present = present_cfg;
endmodule : eiopc_pin_model

// file: dv/tb_eiopc_top.sv
`timescale 1ns/100ps
module tb_eiopc_top import eiopc_pkg::*; ();
  logic         core_clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, rd;
  logic [3:0]   wstrb;
  logic         awready, wready, bvalid, arready, rvalid, seen_p, seen_b;
  logic [1:0]   bresp, rresp;
  logic [135:0] pin_in, pin_out, pin_oe, ext_level, exp_oe, exp_out, pad;
  logic [15:0]  present_cfg, expander_present;
  logic         port_change_handler, pin_change_handler;
  int           err_count, total_checks;

  eiopc_top i_eiopc_top (.core_clk(core_clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .expander_present(expander_present), .port_change_handler(port_change_handler),
    .pin_change_handler(pin_change_handler));
  eiopc_pin_model i_eiopc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_level(ext_level), .present_cfg(present_cfg), .pin_in(pin_in),
    .expander_present(expander_present));

  // ***************************************************************
  // Checking and bus tasks
  // ***************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Address and data offered together, each dropped when taken
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge core_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        check("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100) check("write answer", 32'h1, 32'h0);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    d = 32'h0;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        check("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        break;
      end
    end
    if (n == 100) check("read answer", 32'h1, 32'h0);
  endtask : bus_read

  // Poll until the generator offers a byte; a bounded number of tries
  task automatic expect_byte(input logic [7:0] eb);
    logic [31:0] d;
    int n;
    for (n = 0; n < 40; n++) begin
      bus_read(REPLY_OFFSET, d, RESP_OKAY);
      if (d[REPLY_VALID_BIT] === 1'b1) break;
    end
    check("reply byte", {23'h0, 1'b1, eb}, {23'h0, d[REPLY_VALID_BIT], d[7:0]});
  endtask : expect_byte

  function automatic logic [31:0] cmd(input logic [2:0] op, input logic [7:0] i,
                                      input logic [7:0] c);
    return {8'h00, c, i, 5'h00, op};
  endfunction : cmd

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ***************************************************************
  // Clock, watchdog and test sequence
  // ***************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Whole sequence needs a few hundred cycles; far more means a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("BAD watchdog expected finish seen hang");
    wrap_up();
  end

  initial begin
    err_count = 0; total_checks = 0; reset = 1'b1;
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'hF; wvalid = 1'b0;
    bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
    ext_level = {17{8'h3C}}; present_cfg = 16'hA5C3;
    exp_oe = '0; exp_out = '0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    check("reset oe", 32'h0, {31'h0, |pin_oe});
    check("reset out", 32'h0, {31'h0, |pin_out});
    // Port direction across two ports, then the last port
    bus_write(CMD_OFFSET, cmd(OP_PORT_DIR, 8'd0, 8'd0), RESP_OKAY);
    bus_write(DATA_OFFSET, 32'hE9, RESP_OKAY);
    bus_write(DATA_OFFSET, 32'h0F, RESP_OKAY);
    bus_write(CMD_OFFSET, cmd(OP_PORT_DIR, 8'd16, 8'd0), RESP_OKAY);
    bus_write(DATA_OFFSET, 32'h00, RESP_OKAY);
    exp_oe[15:0] = 16'hF016; exp_oe[135:128] = 8'hFF;
    check("port oe", {16'h0, exp_oe[15:0]}, {16'h0, pin_oe[15:0]});
    check("last port oe", 32'hFF, {24'h0, pin_oe[135:128]});
    // Port writes
    bus_write(CMD_OFFSET, cmd(OP_PORT_WR, 8'd0, 8'd0), RESP_OKAY);
    bus_write(DATA_OFFSET, 32'hA5, RESP_OKAY);
    bus_write(DATA_OFFSET, 32'h5A, RESP_OKAY);
    exp_out[15:0] = 16'h5AA5;
    check("port out", 32'h5AA5, {16'h0, pin_out[15:0]});
    // Single pins: direction, set, invert, ignored code
    bus_write(CMD_OFFSET, cmd(OP_PIN_DIR, 8'd16, 8'd0), RESP_OKAY);
    bus_write(DATA_OFFSET, 32'h0, RESP_OKAY);
    bus_write(DATA_OFFSET, 32'h1, RESP_OKAY);
    exp_oe[16] = 1'b1;
    check("pin oe", 32'h01, {24'h0, pin_oe[23:16]});
    // A pin number past the last line is ignored
    bus_write(CMD_OFFSET, cmd(OP_PIN_DIR, 8'd200, 8'd0), RESP_OKAY);
    bus_write(DATA_OFFSET, 32'h0, RESP_OKAY);
    check("pin beyond range", 32'hFF01, {16'h0, pin_oe[135:128], pin_oe[23:16]});
    bus_write(CMD_OFFSET, cmd(OP_PIN_WR, 8'd16, 8'd0), RESP_OKAY);
    bus_write(DATA_OFFSET, 32'h1, RESP_OKAY);
    bus_write(DATA_OFFSET, 32'h1, RESP_OKAY);
    check("pin set", 32'h03, {24'h0, pin_out[23:16]});
    bus_write(CMD_OFFSET, cmd(OP_PIN_WR, 8'd16, 8'd0), RESP_OKAY);
    bus_write(DATA_OFFSET, {30'h0, PIN_SET_TOGGLE}, RESP_OKAY);
    bus_write(DATA_OFFSET, 32'h3, RESP_OKAY);
    bus_write(DATA_OFFSET, 32'h0, RESP_OKAY);
    exp_out[18:16] = 3'b010;
    check("pin invert", 32'h02, {24'h0, pin_out[23:16]});
    repeat (8) @(posedge core_clk);
    pad = (exp_oe & exp_out) | (~exp_oe & ext_level);
    // Port read reply frame, nothing pending beforehand
    bus_read(REPLY_OFFSET, rd, RESP_OKAY);
    check("reply idle", 32'h0, {31'h0, rd[REPLY_VALID_BIT]});
    bus_write(CMD_OFFSET, cmd(OP_PORT_RD, 8'd0, 8'd2), RESP_OKAY);
    expect_byte(BYTE_ESC); expect_byte(8'h48); expect_byte(8'h50);
    expect_byte(8'h52); expect_byte(8'h00); expect_byte(8'h02);
    expect_byte(pad[7:0]); expect_byte(pad[15:8]);
    // Presence frame and status mirror
    bus_write(CMD_OFFSET, cmd(OP_PRESENCE, 8'd0, 8'd0), RESP_OKAY);
    expect_byte(BYTE_ESC); expect_byte(8'h48); expect_byte(8'h50);
    expect_byte(8'h49); expect_byte(8'hC3); expect_byte(8'hA5);
    bus_read(STATUS_OFFSET, rd, RESP_OKAY);
    check("presence", 32'hA5C3, {16'h0, rd[15:0]});
    // Pin read with default count
    bus_write(CMD_OFFSET, cmd(OP_PIN_RD, 8'd12, 8'd0), RESP_OKAY);
    expect_byte(BYTE_ESC); expect_byte(8'h48); expect_byte(8'h42);
    expect_byte(8'h52); expect_byte(8'h0C); expect_byte(8'h08);
    for (int i = 12; i < 20; i++) expect_byte({7'h0, pad[i]});
    bus_read(REPLY_OFFSET, rd, RESP_OKAY);
    check("reply empty", 32'h0, {31'h0, rd[REPLY_VALID_BIT]});
    bus_read(CMD_OFFSET, rd, RESP_OKAY);
    check("cmd readback", 32'h0008_0C07, rd);
    // Refused accesses
    bus_write(8'h20, 32'h1, RESP_DECERR);
    bus_read(8'h20, rd, RESP_DECERR);
    bus_write(REPLY_OFFSET, 32'h0, RESP_DECERR);
    // Input change raises both handlers and the sticky flag
    bus_write(CTRL_OFFSET, 32'h3, RESP_OKAY);
    bus_read(CTRL_OFFSET, rd, RESP_OKAY);
    check("ctrl", 32'h3, rd);
    @(posedge core_clk);
    ext_level[40] <= ~ext_level[40];
    seen_p = 1'b0; seen_b = 1'b0;
    repeat (20) begin
      @(posedge core_clk);
      if (port_change_handler === 1'b1) seen_p = 1'b1;
      if (pin_change_handler === 1'b1) seen_b = 1'b1;
    end
    check("handlers", 32'h3, {30'h0, seen_p, seen_b});
    bus_read(STATUS_OFFSET, rd, RESP_OKAY);
    check("change flag", 32'h1, {31'h0, rd[STATUS_CHANGE_BIT]});
    bus_write(STATUS_OFFSET, 32'h1 << STATUS_CHANGE_BIT, RESP_OKAY);
    bus_read(STATUS_OFFSET, rd, RESP_OKAY);
    check("flag cleared", 32'h0, {31'h0, rd[STATUS_CHANGE_BIT]});
    check("out held", 32'h5AA5, {16'h0, pin_out[15:0]});
    wrap_up();
  end
endmodule : tb_eiopc_top
